// file: include/cxd_pkg.sv
// Package: constants for the extended display control register bank
`default_nettype none
package cxd_pkg;

  // ----------------------------------------------------------------------
  // Register indices behind the data port
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_TIMING_OVERFLOW = 8'h25;
  localparam logic [7:0] IDX_FIFO_FILL_LIMIT = 8'h27;
  localparam logic [7:0] IDX_PALETTE_DAC     = 8'h28;

  // ----------------------------------------------------------------------
  // Port selection of the indexed pair
  // ----------------------------------------------------------------------
  localparam logic PORT_INDEX = 1'b0;
  localparam logic PORT_DATA  = 1'b1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_TIMING_OVERFLOW = 8'hff;
  localparam logic [7:0] RST_FIFO_FILL_LIMIT = 8'hd0;
  localparam logic [7:0] RST_PALETTE_DAC     = 8'h08;
  localparam logic [7:0] RST_INDEX           = 8'h00;

  // ----------------------------------------------------------------------
  // Read masks: zero bits read as zero
  // ----------------------------------------------------------------------
  localparam logic [7:0] RDMASK_TIMING_OVERFLOW = 8'h3f;
  localparam logic [7:0] RDMASK_FIFO_FILL_LIMIT = 8'hf8;
  localparam logic [7:0] RDMASK_PALETTE_DAC     = 8'hff;
  localparam logic [7:0] RD_UNMAPPED            = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions, timing overflow register
  // ----------------------------------------------------------------------
  localparam int TOV_HBLANK_END = 4;
  localparam int TOV_VBLANK_ST  = 3;
  localparam int TOV_VRETRACE   = 2;
  localparam int TOV_VDISP_END  = 1;
  localparam int TOV_VTOTAL     = 0;

  // ----------------------------------------------------------------------
  // Field positions, fill limit and palette control
  // ----------------------------------------------------------------------
  localparam int FFL_LIMIT_HI   = 7;
  localparam int FFL_LIMIT_LO   = 3;
  localparam int PDC_POWER_OFF  = 7;
  localparam int PDC_PEDESTAL   = 6;
  localparam int PDC_SENSE_OFF  = 5;
  localparam int PDC_TABLE_SKIP = 3;
  localparam int PDC_DEPTH_HI   = 2;
  localparam int PDC_DEPTH_LO   = 0;

  // ----------------------------------------------------------------------
  // Pixel depth codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CXD_DEPTH_STD8   = 3'b000,
    CXD_DEPTH_EXT8   = 3'b001,
    CXD_DEPTH_RGB555 = 3'b010,
    CXD_DEPTH_RGB565 = 3'b011,
    CXD_DEPTH_RGB888 = 3'b100,
    CXD_DEPTH_RGB8888 = 3'b101,
    CXD_DEPTH_RSV6   = 3'b110,
    CXD_DEPTH_RSV7   = 3'b111
  } cxd_depth_e;

endpackage : cxd_pkg
`default_nettype wire

// file: rtl/cxd_ext_display_ctrl.sv
// Extended display control register bank with timing, fetch and pixel-path controls
//
// Behaviour
// - Timing overflow bit 4 drives horizontal blanking end bit 6.
// - Timing overflow bits 3..0 drive bit 10 of four vertical timing values.
// - Timing overflow bits 7 and 6 always read as zero.
// - Stall display FIFO fetches while occupancy is above the fill limit.
// - Palette bit 7 powers down the converters.
// - Palette bit 6 selects 0 or 7.5 IRE blanking pedestal.
// - Palette bit 5 powers down the monitor sense circuitry.
// - Palette bit 3 sends pixels straight to converters, else through table.
// - Palette bits 2..0 pick pixel depth; codes 11x are reserved.
// - 15/16-bit components left-justify into 8 bits, low bits zero.
// - Reset loads FFh, D0h and 08h into the three registers.
// - Fill limit bits 2..0 always read as zero.
`default_nettype none
module cxd_ext_display_ctrl (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Indexed register port pair
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_port_sel,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // Timing overflow bits
  output logic             hblank_end_msb,
  output logic             vblank_start_msb,
  output logic             vretrace_start_msb,
  output logic             vdisplay_end_msb,
  output logic             vtotal_msb,
  // Display FIFO fetch control
  input  wire logic [7:0]  fifo_level,
  output logic             fetch_stall,
  // Converter and sense controls
  output logic             converter_power_off,
  output logic             pedestal_7p5_ire,
  output logic             monitor_sense_power_off,
  output logic             colour_table_skip,
  output logic      [2:0]  pixel_depth_sel,
  output logic             pixel_depth_reserved,
  // Pixel path
  input  wire logic        pixel_valid,
  input  wire logic [31:0] pixel_word,
  output logic      [23:0] pixel_rgb,
  output logic             pixel_to_dac_valid,
  output logic             pixel_to_table_valid
);

  // ----------------------------------------------------------------------
  // Read decode, shared by the data port read and nothing else mapped
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_select(
    input logic [7:0] idx,
    input logic [7:0] tov,
    input logic [7:0] ffl,
    input logic [7:0] pdc
  );
    case (idx)
      cxd_pkg::IDX_TIMING_OVERFLOW: read_select = tov & cxd_pkg::RDMASK_TIMING_OVERFLOW;
      cxd_pkg::IDX_FIFO_FILL_LIMIT: read_select = ffl & cxd_pkg::RDMASK_FIFO_FILL_LIMIT;
      cxd_pkg::IDX_PALETTE_DAC:     read_select = pdc & cxd_pkg::RDMASK_PALETTE_DAC;
      default:                      read_select = cxd_pkg::RD_UNMAPPED;
    endcase
  endfunction : read_select

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
    hit = (idx == target);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Register bank state
  // ----------------------------------------------------------------------
  logic [7:0] index_reg;
  logic [7:0] index_next;
  logic [7:0] tov_reg;
  logic [7:0] tov_next;
  logic [7:0] ffl_reg;
  logic [7:0] ffl_next;
  logic [7:0] pdc_reg;
  logic [7:0] pdc_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic index_wr;
  logic index_rd;
  logic data_wr;
  logic data_rd;

  assign index_wr = io_wr & (io_port_sel == cxd_pkg::PORT_INDEX);
  assign index_rd = io_rd & (io_port_sel == cxd_pkg::PORT_INDEX);
  assign data_wr  = io_wr & (io_port_sel == cxd_pkg::PORT_DATA);
  assign data_rd  = io_rd & (io_port_sel == cxd_pkg::PORT_DATA);

  always_comb begin
    index_next = index_reg;
    tov_next   = tov_reg;
    ffl_next   = ffl_reg;
    pdc_next   = pdc_reg;
    rdata_next = rdata_reg;
    if (index_wr) begin
      index_next = io_wdata;
    end
    if (data_wr) begin
      // Writes land in the register last indexed; unmapped indices are ignored
      if (hit(index_reg, cxd_pkg::IDX_TIMING_OVERFLOW)) begin
        tov_next = io_wdata;
      end
      if (hit(index_reg, cxd_pkg::IDX_FIFO_FILL_LIMIT)) begin
        // Low bits are not stored so they can never read back
        ffl_next = io_wdata & cxd_pkg::RDMASK_FIFO_FILL_LIMIT;
      end
      if (hit(index_reg, cxd_pkg::IDX_PALETTE_DAC)) begin
        // Reserved bit 4 is stored as written; keeping it at one is left to software
        pdc_next = io_wdata;
      end
    end
    // A read in the same cycle as a write sees the bank as it stood before it
    if (index_rd) begin
      rdata_next = index_reg;
    end
    if (data_rd) begin
      rdata_next = read_select(index_reg, tov_reg, ffl_reg, pdc_reg);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      index_reg <= cxd_pkg::RST_INDEX;
      tov_reg   <= cxd_pkg::RST_TIMING_OVERFLOW;
      ffl_reg   <= cxd_pkg::RST_FIFO_FILL_LIMIT;
      pdc_reg   <= cxd_pkg::RST_PALETTE_DAC;
      rdata_reg <= cxd_pkg::RD_UNMAPPED;
    end else begin
      index_reg <= index_next;
      tov_reg   <= tov_next;
      ffl_reg   <= ffl_next;
      pdc_reg   <= pdc_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Reset images of the derived outputs
  // ----------------------------------------------------------------------
  // Built from the bank's reset values so the pins agree with a read-back
  // from the first cycle after reset, before any write has reached them.
  localparam logic [4:0] TMSB_RESET = {
    cxd_pkg::RST_TIMING_OVERFLOW[cxd_pkg::TOV_HBLANK_END],
    cxd_pkg::RST_TIMING_OVERFLOW[cxd_pkg::TOV_VBLANK_ST],
    cxd_pkg::RST_TIMING_OVERFLOW[cxd_pkg::TOV_VRETRACE],
    cxd_pkg::RST_TIMING_OVERFLOW[cxd_pkg::TOV_VDISP_END],
    cxd_pkg::RST_TIMING_OVERFLOW[cxd_pkg::TOV_VTOTAL]
  };

  localparam logic [3:0] CTL_RESET = {
    cxd_pkg::RST_PALETTE_DAC[cxd_pkg::PDC_POWER_OFF],
    cxd_pkg::RST_PALETTE_DAC[cxd_pkg::PDC_PEDESTAL],
    cxd_pkg::RST_PALETTE_DAC[cxd_pkg::PDC_SENSE_OFF],
    cxd_pkg::RST_PALETTE_DAC[cxd_pkg::PDC_TABLE_SKIP]
  };

  localparam logic [2:0] DEPTH_RESET = cxd_pkg::RST_PALETTE_DAC[cxd_pkg::PDC_DEPTH_HI:cxd_pkg::PDC_DEPTH_LO];

  // ----------------------------------------------------------------------
  // Control outputs, registered one cycle behind the bank
  // ----------------------------------------------------------------------
  // One extra edge on the pins keeps the read mux apart from the timing fan-out
  logic [4:0] tmsb_reg;
  logic [4:0] tmsb_next;
  logic [3:0] ctl_reg;
  logic [3:0] ctl_next;

  always_comb begin
    tmsb_next = {tov_reg[cxd_pkg::TOV_HBLANK_END],
                 tov_reg[cxd_pkg::TOV_VBLANK_ST],
                 tov_reg[cxd_pkg::TOV_VRETRACE],
                 tov_reg[cxd_pkg::TOV_VDISP_END],
                 tov_reg[cxd_pkg::TOV_VTOTAL]};
    ctl_next  = {pdc_reg[cxd_pkg::PDC_POWER_OFF],
                 pdc_reg[cxd_pkg::PDC_PEDESTAL],
                 pdc_reg[cxd_pkg::PDC_SENSE_OFF],
                 pdc_reg[cxd_pkg::PDC_TABLE_SKIP]};
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tmsb_reg <= TMSB_RESET;
      ctl_reg  <= CTL_RESET;
    end else begin
      tmsb_reg <= tmsb_next;
      ctl_reg  <= ctl_next;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch throttle
  // ----------------------------------------------------------------------
  // The limit field counts in units of eight entries, so it is compared as the
  // byte it occupies; occupancy equal to the limit still fetches.
  logic       stall_reg;
  logic       stall_next;
  logic [7:0] limit_level;

  assign limit_level = {ffl_reg[cxd_pkg::FFL_LIMIT_HI:cxd_pkg::FFL_LIMIT_LO], 3'h0};

  always_comb begin
    stall_next = (fifo_level > limit_level);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stall_reg <= 1'b0;
    end else begin
      stall_reg <= stall_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pixel path
  // ----------------------------------------------------------------------
  logic [2:0]  depth_sel;
  logic [23:0] wide_rgb;
  logic        wide_reserved;
  logic [23:0] rgb_reg;
  logic [23:0] rgb_next;
  logic        dac_vld_reg;
  logic        dac_vld_next;
  logic        tbl_vld_reg;
  logic        tbl_vld_next;
  logic [2:0]  depth_reg;
  logic        rsv_reg;
  logic        pixel_accept;

  assign depth_sel = pdc_reg[cxd_pkg::PDC_DEPTH_HI:cxd_pkg::PDC_DEPTH_LO];

  // Gating reads the bank bit, not the delayed pin, so a power-down stops the next pixel
  assign pixel_accept = pixel_valid & ~pdc_reg[cxd_pkg::PDC_POWER_OFF] & ~wide_reserved;

  cxd_pixel_widen u_widen (
    .depth_sel      (depth_sel),
    .pixel_word     (pixel_word),
    .rgb_out        (wide_rgb),
    .depth_reserved (wide_reserved)
  );

  always_comb begin
    rgb_next     = rgb_reg;
    dac_vld_next = 1'b0;
    tbl_vld_next = 1'b0;
    // Powered-down converters and reserved formats emit nothing
    if (pixel_accept) begin
      rgb_next = wide_rgb;
      if (pdc_reg[cxd_pkg::PDC_TABLE_SKIP]) begin
        dac_vld_next = 1'b1;
      end else begin
        tbl_vld_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rgb_reg     <= 24'h000000;
      dac_vld_reg <= 1'b0;
      tbl_vld_reg <= 1'b0;
      depth_reg   <= DEPTH_RESET;
      rsv_reg     <= 1'b0;
    end else begin
      rgb_reg     <= rgb_next;
      dac_vld_reg <= dac_vld_next;
      tbl_vld_reg <= tbl_vld_next;
      depth_reg   <= depth_sel;
      rsv_reg     <= wide_reserved;
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  assign io_rdata                = rdata_reg;
  assign hblank_end_msb          = tmsb_reg[4];
  assign vblank_start_msb        = tmsb_reg[3];
  assign vretrace_start_msb      = tmsb_reg[2];
  assign vdisplay_end_msb        = tmsb_reg[1];
  assign vtotal_msb              = tmsb_reg[0];
  assign fetch_stall             = stall_reg;
  assign converter_power_off     = ctl_reg[3];
  assign pedestal_7p5_ire        = ctl_reg[2];
  assign monitor_sense_power_off = ctl_reg[1];
  assign colour_table_skip       = ctl_reg[0];
  assign pixel_depth_sel         = depth_reg;
  assign pixel_depth_reserved    = rsv_reg;
  assign pixel_rgb               = rgb_reg;
  assign pixel_to_dac_valid      = dac_vld_reg;
  assign pixel_to_table_valid    = tbl_vld_reg;

endmodule : cxd_ext_display_ctrl
`default_nettype wire

// file: rtl/cxd_pixel_widen.sv
// Combinational pixel widener: unpacks a pixel word into three 8-bit components
`default_nettype none
module cxd_pixel_widen (
  // Format and pixel
  input  wire logic [2:0]  depth_sel,
  input  wire logic [31:0] pixel_word,
  // Widened result
  output logic      [23:0] rgb_out,
  output logic             depth_reserved
);

  // ----------------------------------------------------------------------
  // Left-justify helpers, low bits filled with zero
  // ----------------------------------------------------------------------
  function automatic logic [7:0] widen5(input logic [4:0] c);
    widen5 = {c, 3'h0};
  endfunction : widen5

  function automatic logic [7:0] widen6(input logic [5:0] c);
    widen6 = {c, 2'h0};
  endfunction : widen6

  always_comb begin
    rgb_out        = 24'h000000;
    depth_reserved = 1'b0;
    case (cxd_pkg::cxd_depth_e'(depth_sel))
      cxd_pkg::CXD_DEPTH_STD8,
      cxd_pkg::CXD_DEPTH_EXT8: begin
        // 8-bit modes carry a table index in the low byte
        rgb_out = {16'h0000, pixel_word[7:0]};
      end
      cxd_pkg::CXD_DEPTH_RGB555: begin
        rgb_out = {widen5(pixel_word[14:10]), widen5(pixel_word[9:5]), widen5(pixel_word[4:0])};
      end
      cxd_pkg::CXD_DEPTH_RGB565: begin
        rgb_out = {widen5(pixel_word[15:11]), widen6(pixel_word[10:5]), widen5(pixel_word[4:0])};
      end
      cxd_pkg::CXD_DEPTH_RGB888,
      cxd_pkg::CXD_DEPTH_RGB8888: begin
        // Alpha byte of 32-bit pixels is not displayed
        rgb_out = pixel_word[23:0];
      end
      default: begin
        depth_reserved = 1'b1;
      end
    endcase
  end

endmodule : cxd_pixel_widen
`default_nettype wire

// file: testbench/cxd_ext_display_ctrl_monitor.sv
// Checker for the extended display control register bank
`default_nettype none
module cxd_ext_display_ctrl_monitor (
  // Clock, reset and register port
  input wire logic        clock, reset_n, io_wr, io_rd, io_port_sel,
  input wire logic [7:0]  io_wdata, io_rdata, fifo_level,
  // Decoded controls
  input wire logic        hblank_end_msb, vblank_start_msb, vretrace_start_msb, vdisplay_end_msb, vtotal_msb,
  input wire logic        fetch_stall, converter_power_off, pedestal_7p5_ire, monitor_sense_power_off,
  input wire logic        colour_table_skip, pixel_depth_reserved,
  input wire logic [2:0]  pixel_depth_sel,
  // Pixel path
  input wire logic        pixel_valid, pixel_to_dac_valid, pixel_to_table_valid,
  input wire logic [31:0] pixel_word,
  input wire logic [23:0] pixel_rgb
);
  // ----------------------------------------------------------------------
  // Shadow state, so outputs can be tied to what software wrote
  // ----------------------------------------------------------------------
  logic [7:0]  idx_reg, lim_reg, pal_reg;
  logic        data_wr, stall_cond, pix_ok;
  logic [23:0] wide_exp;
  assign data_wr    = io_wr && io_port_sel;
  assign stall_cond = fifo_level > lim_reg;
  assign pix_ok     = pixel_valid && !pal_reg[7] && (pal_reg[2:1] != 2'h3);
  assign wide_exp   = pal_reg[0] ? {pixel_word[15:11], 3'h0, pixel_word[10:5], 2'h0, pixel_word[4:0], 3'h0}
                                 : {pixel_word[14:10], 3'h0, pixel_word[9:5], 3'h0, pixel_word[4:0], 3'h0};
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idx_reg <= 8'h00;
      lim_reg <= 8'hd0;
      pal_reg <= 8'h08;
    end else begin
      if (io_wr && !io_port_sel) idx_reg <= io_wdata;
      if (data_wr && idx_reg == cxd_pkg::IDX_FIFO_FILL_LIMIT) lim_reg <= io_wdata & 8'hf8;
      if (data_wr && idx_reg == cxd_pkg::IDX_PALETTE_DAC) pal_reg <= io_wdata;
    end
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_TOV_MAP: assert property (data_wr && idx_reg == 8'h25 |-> ##2
    {3'h0, hblank_end_msb, vblank_start_msb, vretrace_start_msb, vdisplay_end_msb, vtotal_msb} ==
    ($past(io_wdata, 2) & 8'h1f)) else $error("timing bits wrong");
  AST_TOV_READ: assert property (io_rd && io_port_sel && idx_reg == 8'h25 |=> io_rdata[7:6] == 2'h0)
    else $error("timing overflow upper bits not zero");
  AST_FFL_READ: assert property (io_rd && io_port_sel && idx_reg == 8'h27 |=> io_rdata[2:0] == 3'h0)
    else $error("fill limit low bits not zero");
  AST_STALL_SET: assert property (stall_cond |=> fetch_stall) else $error("fetch not stalled");
  AST_STALL_CLEAR: assert property (!stall_cond |=> !fetch_stall) else $error("fetch not resumed");
  AST_PAL_MAP: assert property (data_wr && idx_reg == 8'h28 |-> ##2
    {converter_power_off, pedestal_7p5_ire, monitor_sense_power_off, 1'b0, colour_table_skip, pixel_depth_sel} ==
    ($past(io_wdata, 2) & 8'hef)) else $error("palette controls wrong");
  AST_RSV_FLAG: assert property (pixel_depth_reserved == (pixel_depth_sel[2:1] == 2'h3))
    else $error("reserved depth flag wrong");
  AST_ROUTE: assert property (pix_ok |=> {pixel_to_dac_valid, pixel_to_table_valid} ==
    ((($past(pal_reg) & 8'h08) != 8'h00) ? 2'h2 : 2'h1)) else $error("pixel routed wrongly");
  AST_REFUSE: assert property (!pix_ok |=> !pixel_to_dac_valid && !pixel_to_table_valid)
    else $error("pixel passed while refused");
  AST_WIDEN: assert property (pix_ok && pal_reg[2:1] == 2'h1 |=> pixel_rgb == $past(wide_exp))
    else $error("pixel widening wrong");
  // Main scenarios
  COV_PAL_WR: cover property (data_wr && idx_reg == 8'h28);
  COV_STALL: cover property (fetch_stall);
  COV_DAC: cover property (pixel_to_dac_valid);
  COV_TABLE: cover property (pixel_to_table_valid);
endmodule : cxd_ext_display_ctrl_monitor

bind cxd_ext_display_ctrl cxd_ext_display_ctrl_monitor u_mon (
  .clock(clock), .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd), .io_port_sel(io_port_sel),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .fifo_level(fifo_level), .hblank_end_msb(hblank_end_msb),
  .vblank_start_msb(vblank_start_msb), .vretrace_start_msb(vretrace_start_msb),
  .vdisplay_end_msb(vdisplay_end_msb), .vtotal_msb(vtotal_msb), .fetch_stall(fetch_stall),
  .converter_power_off(converter_power_off), .pedestal_7p5_ire(pedestal_7p5_ire),
  .monitor_sense_power_off(monitor_sense_power_off), .colour_table_skip(colour_table_skip),
  .pixel_depth_reserved(pixel_depth_reserved), .pixel_depth_sel(pixel_depth_sel), .pixel_valid(pixel_valid),
  .pixel_to_dac_valid(pixel_to_dac_valid), .pixel_to_table_valid(pixel_to_table_valid),
  .pixel_word(pixel_word), .pixel_rgb(pixel_rgb));
`default_nettype wire

// file: testbench/cxd_ext_display_ctrl_test.sv
// Self-checking bench for the extended display control register bank
`default_nettype none
module cxd_ext_display_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
  // ----------------------------------------------------------------------
  // Design hookup
  // ----------------------------------------------------------------------
  localparam logic IX = cxd_pkg::PORT_INDEX;
  localparam logic DT = cxd_pkg::PORT_DATA;
  logic        clock = 1'b0, reset_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, io_port_sel = 1'b0;
  logic [7:0]  io_wdata = 8'h00, fifo_level = 8'h00, io_rdata;
  logic        hblank_end_msb, vblank_start_msb, vretrace_start_msb, vdisplay_end_msb, vtotal_msb, fetch_stall;
  logic        converter_power_off, pedestal_7p5_ire, monitor_sense_power_off, colour_table_skip;
  logic        pixel_depth_reserved, pixel_valid = 1'b0, pixel_to_dac_valid, pixel_to_table_valid;
  logic [2:0]  pixel_depth_sel;
  logic [31:0] pixel_word = 32'h00000000;
  logic [23:0] pixel_rgb, rgb_exp;
  logic [4:0]  tmsb;
  logic [6:0]  ctl;
  assign tmsb = {hblank_end_msb, vblank_start_msb, vretrace_start_msb, vdisplay_end_msb, vtotal_msb};
  assign ctl  = {converter_power_off, pedestal_7p5_ire, monitor_sense_power_off, colour_table_skip, pixel_depth_sel};
  int          bad_count = 0, checks = 0;
  always #2 clock = ~clock;
  cxd_ext_display_ctrl u_dut (.clock(clock), .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd),
    .io_port_sel(io_port_sel), .io_wdata(io_wdata), .io_rdata(io_rdata), .hblank_end_msb(hblank_end_msb),
    .vblank_start_msb(vblank_start_msb), .vretrace_start_msb(vretrace_start_msb),
    .vdisplay_end_msb(vdisplay_end_msb), .vtotal_msb(vtotal_msb), .fifo_level(fifo_level),
    .fetch_stall(fetch_stall), .converter_power_off(converter_power_off), .pedestal_7p5_ire(pedestal_7p5_ire),
    .monitor_sense_power_off(monitor_sense_power_off), .colour_table_skip(colour_table_skip),
    .pixel_depth_sel(pixel_depth_sel), .pixel_depth_reserved(pixel_depth_reserved), .pixel_valid(pixel_valid),
    .pixel_word(pixel_word), .pixel_rgb(pixel_rgb), .pixel_to_dac_valid(pixel_to_dac_valid),
    .pixel_to_table_valid(pixel_to_table_valid));
  // ----------------------------------------------------------------------
  // Port access tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge clock);
    io_wr <= 1'b1;
    io_port_sel <= sel;
    io_wdata <= d;
    @(posedge clock);
    io_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic sel, output logic [7:0] d);
    @(posedge clock);
    io_rd <= 1'b1;
    io_port_sel <= sel;
    @(posedge clock);
    io_rd <= 1'b0;
    #1;
    d = io_rdata;
  endtask : rd
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    wr(IX, idx);
    wr(DT, d);
  endtask : put
  task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    wr(IX, idx);
    rd(DT, d);
    `CHK(d, exp)
  endtask : reg_chk
  // Derived outputs land one edge after the write
  task automatic settle;
    @(posedge clock);
    #1;
  endtask : settle
  task automatic lvl(input logic [7:0] l, input logic exp);
    @(posedge clock);
    fifo_level <= l;
    settle();
    `CHK(fetch_stall, exp)
  endtask : lvl
  task automatic pix(input logic [31:0] w, input logic ok, input logic byp);
    @(posedge clock);
    pixel_valid <= 1'b1;
    pixel_word <= w;
    @(posedge clock);
    pixel_valid <= 1'b0;
    #1;
    `CHK({pixel_to_dac_valid, pixel_to_table_valid}, (ok ? {byp, !byp} : 2'h0))
    `CHK(pixel_rgb, rgb_exp)
  endtask : pix
  // Reserved codes leave the held pixel untouched
  function automatic logic [23:0] widen(input logic [2:0] c, input logic [31:0] w, input logic [23:0] old);
    case (c)
      3'h0, 3'h1: widen = {16'h0000, w[7:0]};
      3'h2: widen = {w[14:10], 3'h0, w[9:5], 3'h0, w[4:0], 3'h0};
      3'h3: widen = {w[15:11], 3'h0, w[10:5], 2'h0, w[4:0], 3'h0};
      3'h4, 3'h5: widen = w[23:0];
      default: widen = old;
    endcase
  endfunction : widen
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin : main
    logic [7:0]  v;
    logic [31:0] w;
    rgb_exp = 24'h000000;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    settle();
    `CHK(tmsb, 5'h1f)
    `CHK(ctl, 7'h08)
    reg_chk(8'h25, 8'h3f);
    reg_chk(8'h27, 8'hd0);
    reg_chk(8'h28, 8'h08);
    rd(IX, v);
    `CHK(v, 8'h28)
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hd5 : 8'h2a;
      put(8'h25, v);
      settle();
      `CHK(tmsb, v[4:0])
      reg_chk(8'h25, v & 8'h3f);
    end
    put(8'h26, 8'h55);
    reg_chk(8'h26, 8'h00);
    reg_chk(8'h25, 8'h2a);
    $display("test timing overflow done");
    put(8'h27, 8'h47);
    reg_chk(8'h27, 8'h40);
    lvl(8'h41, 1'b1);
    lvl(8'h40, 1'b0);
    lvl(8'hff, 1'b1);
    put(8'h27, 8'hd0);
    lvl(8'hd1, 1'b1);
    lvl(8'hd0, 1'b0);
    $display("test fill limit done");
    w = 32'h5ac3e71f;
    for (int c = 0; c < 8; c++) begin
      v = {1'b0, c[0], c[1], 1'b1, c[0] ^ c[1], c[2:0]};
      put(8'h28, v);
      settle();
      `CHK(ctl, {v[7:5], v[3:0]})
      `CHK(pixel_depth_reserved, c[2] & c[1])
      reg_chk(8'h28, v);
      rgb_exp = widen(c[2:0], w, rgb_exp);
      pix(w, !(c[2] & c[1]), v[3]);
      w = w + 32'h01234567;
    end
    put(8'h28, 8'h9b);
    settle();
    `CHK(converter_power_off, 1'b1)
    pix(w, 1'b0, 1'b1);
    put(8'h28, 8'h18);
    for (int k = 8'h29; k <= 8'h32; k++) begin
      put(k[7:0], 8'h00);
    end
    reg_chk(8'h28, 8'h18);
    $display("test palette and pixels done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    settle();
    `CHK(tmsb, 5'h1f)
    rd(IX, v);
    `CHK(v, 8'h00)
    reg_chk(8'h25, 8'h3f);
    reg_chk(8'h27, 8'hd0);
    reg_chk(8'h28, 8'h08);
    $display("test second reset done");
    end_sim();
  end
  // Cuts a hung run short well after the tests should have finished
  initial begin : watchdog
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : cxd_ext_display_ctrl_test
`default_nettype wire
